// file: rtl/spfc_port.sv
// Serial port core: buffers, flags, DMA requests, dual CRC and mode fault logic
// What this block does
// - Enabled with transmit DMA on, request DMA while transmit buffer is empty.
// - Enabled with receive DMA on, request DMA while receive buffer is full.
// - Separate transmit and receive CRCs update every bit outside the CRC frame with programmed polynomial.
// - Set CRC-next after last word; the transmit CRC is shifted out next.
// - In full duplex the word received during CRC send is the partner CRC.
// - Received CRC word differing from receive CRC sets mismatch; write zero clears.
// - With DMA enabled the CRC is sent and checked without software help.
// - Slave CRC advances on serial clocks even while disabled; select stays low.
// - Transmit empty set when buffer holds nothing, cleared by a data write.
// - Receive full set when a word lands, cleared by a data read.
// - Shift active shows a transfer in progress, hardware owned, no interrupt.
// - Master with hardware select and no drive faults when select pin is low.
// - Master with software select faults whenever the software level is zero.
// - Fault clears enable and master; both locked until status access then control write.
// - Word arriving while full sets overrun and is dropped; data read then status read clears.
// - Slave framed mode flags select toggling mid word; write zero clears.
// - Master receive-only clocks continuously; full duplex master waits for data.
`timescale 1ns/1ps
`default_nettype none
module spfc_port #(
    parameter int HALF_CYCLES = spfc_pkg::SCK_HALF_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ctrl_a_wr_i,
    input wire spfc_pkg::spfc_ctrl_a_type ctrl_a_i,
    input wire spfc_pkg::spfc_ctrl_b_type ctrl_b_i,
    input wire logic [7:0] crc_poly_i,
    input wire logic data_wr_i,
    input wire logic [7:0] data_i,
    input wire logic data_rd_i,
    input wire logic status_rd_i,
    input wire logic status_wr_i,
    input wire spfc_pkg::spfc_status_type status_i,
    input wire logic dma_last_i,
    input wire logic sck_i,
    input wire logic nss_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    output logic [7:0] rd_data_o,
    output spfc_pkg::spfc_status_type status_o,
    output logic port_enable_o,
    output logic master_select_o,
    output logic [7:0] tx_check_o,
    output logic [7:0] rx_check_o,
    output logic dma_tx_req_o,
    output logic dma_rx_req_o,
    output logic irq_o,
    output logic sck_o,
    output logic sck_oe_o,
    output logic nss_o,
    output logic nss_oe_o,
    output logic mosi_o,
    output logic mosi_oe_o,
    output logic miso_o,
    output logic miso_oe_o
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } spfc_state_type;

    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic b,
                                            input logic [7:0] poly);
        crc_step = {crc[6:0], 1'b0} ^ ((crc[7] ^ b) ? poly : 8'h00);
    endfunction

    spfc_state_type state_reg;
    spfc_pkg::spfc_ctrl_a_type ctrl_reg;
    logic en_reg, master_reg;
    logic [7:0] tx_buf_reg, rx_buf_reg, tx_sh_reg, rx_sh_reg, tx_crc_reg, rx_crc_reg;
    logic tx_full_reg, rx_full_reg, crc_pend_reg, crc_frame_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] div_cnt_reg;
    logic sck_reg;
    logic sck_s1, sck_s2, sck_s3, nss_s1, nss_s2, nss_s3;
    logic mosi_s1, mosi_s2, miso_s1, miso_s2;
    logic fault_reg, fault_arm_reg, ovr_reg, ovr_arm_reg, frame_sync_error_reg, crc_mismatch_flag_reg;
    logic active_reg, dma_tx_reg, dma_rx_reg, irq_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk_i) begin
        sck_s1 <= sck_i;
        sck_s2 <= sck_s1;
        sck_s3 <= sck_s2;
        nss_s1 <= nss_i;
        nss_s2 <= nss_s1;
        nss_s3 <= nss_s2;
        mosi_s1 <= mosi_i;
        mosi_s2 <= mosi_s1;
        miso_s1 <= miso_i;
        miso_s2 <= miso_s1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Edge generation and frame control
    logic div_hit, m_rise, m_fall, s_sel, rise, fall, in_bit, rx_done, frame_end;
    logic start_m, start_s, start, crc_load, fault_set, frame_sync_error_set, rx_keep;
    logic [7:0] rx_word;
    assign div_hit = (div_cnt_reg == 8'(HALF_CYCLES - 1));
    assign m_rise = master_reg && state_reg == ST_SHIFT && div_hit && !sck_reg;
    assign m_fall = master_reg && state_reg == ST_SHIFT && div_hit && sck_reg;
    // Framed mode counts regardless of select; select only marks frames
    assign s_sel = ctrl_b_i.ti_mode || !nss_s2;
    assign rise = master_reg ? m_rise : (sck_s2 && !sck_s3 && s_sel);
    assign fall = master_reg ? m_fall : (!sck_s2 && sck_s3 && s_sel);
    assign in_bit = master_reg ? miso_s2 : mosi_s2;
    assign rx_word = {rx_sh_reg[6:0], in_bit};
    assign rx_done = rise && bit_cnt_reg == 4'(spfc_pkg::FRAME_BITS - 1);
    assign frame_end = fall && bit_cnt_reg == 4'(spfc_pkg::FRAME_BITS);
    assign start_m = master_reg && en_reg &&
        (tx_full_reg || crc_pend_reg || (ctrl_reg.rx_only && !ctrl_reg.tx_only));
    // Slave keeps shifting while disabled so the CRC still follows the clock
    assign start_s = !master_reg && !nss_s2 && (en_reg || ctrl_reg.crc_enable);
    assign start = state_reg == ST_IDLE && (start_m || start_s);
    assign crc_load = start && crc_pend_reg && !tx_full_reg;
    // Disabled slave shifts for the CRC only; nothing reaches the buffers
    assign rx_keep = rx_done && en_reg && !ctrl_reg.tx_only;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= '0;
            div_cnt_reg <= '0;
            sck_reg <= 1'b0;
            tx_sh_reg <= spfc_pkg::RST_WORD;
            rx_sh_reg <= spfc_pkg::RST_WORD;
            crc_frame_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    sck_reg <= 1'b0;
                    div_cnt_reg <= '0;
                    bit_cnt_reg <= '0;
                    if (start) begin
                        state_reg <= ST_SHIFT;
                        tx_sh_reg <= crc_load ? tx_crc_reg : tx_buf_reg;
                        crc_frame_reg <= crc_load;
                    end
                end
                ST_SHIFT: begin
                    if (master_reg) begin
                        div_cnt_reg <= div_hit ? 8'h00 : div_cnt_reg + 8'h01;
                        if (div_hit) begin
                            sck_reg <= !sck_reg;
                        end
                    end
                    if (rise) begin
                        rx_sh_reg <= rx_word;
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    if (frame_end || (!master_reg && !ctrl_b_i.ti_mode && nss_s2)) begin
                        state_reg <= ST_IDLE;
                    end else if (fall) begin
                        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Buffers and data flags; a set of either full flag wins over a same-cycle clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_buf_reg <= spfc_pkg::RST_WORD;
            rx_buf_reg <= spfc_pkg::RST_WORD;
            tx_full_reg <= 1'b0;
            rx_full_reg <= 1'b0;
        end else begin
            if (data_wr_i) begin
                tx_buf_reg <= data_i;
                tx_full_reg <= 1'b1;
            end else if (start && !crc_load) begin
                tx_full_reg <= 1'b0;
            end
            if (rx_keep && !rx_full_reg) begin
                rx_buf_reg <= rx_word;
                rx_full_reg <= 1'b1;
            end else if (data_rd_i) begin
                rx_full_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // CRC calculators and CRC phase request
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !ctrl_reg.crc_enable) begin
            tx_crc_reg <= spfc_pkg::RST_CRC;
            rx_crc_reg <= spfc_pkg::RST_CRC;
        end else if (rise && !crc_frame_reg) begin
            tx_crc_reg <= crc_step(tx_crc_reg, tx_sh_reg[7], crc_poly_i);
            rx_crc_reg <= crc_step(rx_crc_reg, in_bit, crc_poly_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            crc_pend_reg <= 1'b0;
        end else if (ctrl_a_wr_i && ctrl_a_i.crc_next_transfer && ctrl_a_i.crc_enable) begin
            crc_pend_reg <= 1'b1;
        end else if (dma_last_i && ctrl_reg.crc_enable &&
                     (ctrl_b_i.dma_tx_request_enable || ctrl_b_i.dma_rx_request_enable)) begin
            crc_pend_reg <= 1'b1;
        end else if (start) begin
            crc_pend_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control bits with mode fault protection
    assign fault_set = master_reg && ((ctrl_reg.soft_select_mode &&
        !ctrl_reg.soft_select_level) ||
        (!ctrl_reg.soft_select_mode && !ctrl_b_i.select_output_drive && !nss_s2));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= spfc_pkg::RST_CTRL_A;
            en_reg <= 1'b0;
            master_reg <= 1'b0;
        end else begin
            if (ctrl_a_wr_i) begin
                ctrl_reg <= ctrl_a_i;
            end
            if (fault_set) begin
                en_reg <= 1'b0;
                master_reg <= 1'b0;
            end else if (ctrl_a_wr_i && !fault_reg) begin
                en_reg <= ctrl_a_i.port_enable;
                master_reg <= ctrl_a_i.master_select;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Error flags
    assign frame_sync_error_set = !master_reg && ctrl_b_i.ti_mode && en_reg && state_reg == ST_SHIFT &&
        bit_cnt_reg != 4'h0 && nss_s2 != nss_s3;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fault_reg <= 1'b0;
            fault_arm_reg <= 1'b0;
            ovr_reg <= 1'b0;
            ovr_arm_reg <= 1'b0;
            frame_sync_error_reg <= 1'b0;
            crc_mismatch_flag_reg <= 1'b0;
        end else begin
            // Clearing needs a status access first, so a stray control write cannot
            if (fault_set) begin
                fault_reg <= 1'b1;
            end else if (ctrl_a_wr_i && fault_arm_reg) begin
                fault_reg <= 1'b0;
            end
            if (status_rd_i || status_wr_i) begin
                fault_arm_reg <= fault_reg;
            end else if (ctrl_a_wr_i) begin
                fault_arm_reg <= 1'b0;
            end
            if (rx_keep && rx_full_reg) begin
                ovr_reg <= 1'b1;
            end else if (status_rd_i && ovr_arm_reg) begin
                ovr_reg <= 1'b0;
            end
            if (data_rd_i) begin
                ovr_arm_reg <= ovr_reg;
            end else if (status_rd_i) begin
                ovr_arm_reg <= 1'b0;
            end
            if (frame_sync_error_set) begin
                frame_sync_error_reg <= 1'b1;
            end else if (status_wr_i && !status_i.frame_sync_error) begin
                frame_sync_error_reg <= 1'b0;
            end
            // Word received during the CRC frame is the partner's CRC
            if (rx_done && crc_frame_reg && rx_word != rx_crc_reg) begin
                crc_mismatch_flag_reg <= 1'b1;
            end else if (status_wr_i && !status_i.crc_mismatch_flag) begin
                crc_mismatch_flag_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Requests, interrupt and pins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            active_reg <= 1'b0;
            dma_tx_reg <= 1'b0;
            dma_rx_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            // Busy from the start cycle until the shifter is idle; a waiting word alone does not set it
            active_reg <= state_reg != ST_IDLE || start;
            dma_tx_reg <= en_reg && ctrl_b_i.dma_tx_request_enable && !tx_full_reg;
            dma_rx_reg <= en_reg && ctrl_b_i.dma_rx_request_enable && rx_full_reg;
            irq_reg <= (ctrl_b_i.tx_empty_irq_enable && !tx_full_reg) ||
                (ctrl_b_i.rx_full_irq_enable && rx_full_reg) ||
                (ctrl_b_i.error_irq_enable &&
                 (fault_reg || ovr_reg || frame_sync_error_reg || crc_mismatch_flag_reg));
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sck_oe_o <= 1'b0;
            nss_oe_o <= 1'b0;
            mosi_oe_o <= 1'b0;
            miso_oe_o <= 1'b0;
        end else begin
            sck_oe_o <= master_reg && en_reg;
            nss_oe_o <= master_reg && en_reg && ctrl_b_i.select_output_drive;
            mosi_oe_o <= master_reg && en_reg;
            miso_oe_o <= !master_reg && en_reg && !nss_s2;
        end
    end

    always_ff @(posedge clk_i) begin
        sck_o <= sck_reg;
        nss_o <= 1'b0;
        mosi_o <= tx_sh_reg[7];
        miso_o <= tx_sh_reg[7];
    end

    assign rd_data_o = rx_buf_reg;
    assign port_enable_o = en_reg;
    assign master_select_o = master_reg;
    assign tx_check_o = tx_crc_reg;
    assign rx_check_o = rx_crc_reg;
    assign dma_tx_req_o = dma_tx_reg;
    assign dma_rx_req_o = dma_rx_reg;
    assign irq_o = irq_reg;
    assign status_o = '{tx_buffer_empty: !tx_full_reg, rx_full: rx_full_reg,
        shift_active_flag: active_reg, mode_fault_flag: fault_reg,
        rx_overrun_flag: ovr_reg, frame_sync_error: frame_sync_error_reg,
        crc_mismatch_flag: crc_mismatch_flag_reg};

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_dma_tx;
        (en_reg && ctrl_b_i.dma_tx_request_enable && status_o.tx_buffer_empty) |=> dma_tx_req_o;
    endproperty
    a_dma_tx: assert property (p_dma_tx) else $error("tx dma request missing");

    property p_dma_rx;
        !rx_full_reg ##1 rx_full_reg && en_reg && ctrl_b_i.dma_rx_request_enable
            |=> dma_rx_req_o;
    endproperty
    a_dma_rx: assert property (p_dma_rx) else $error("rx dma request missing");

    property p_tx_clear;
        data_wr_i |=> !status_o.tx_buffer_empty;
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("write left buffer empty");

    property p_rx_set;
        rx_keep && !rx_full_reg |=> status_o.rx_full && rd_data_o == $past(rx_word);
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("received word not stored");

    property p_overrun;
        rx_keep && rx_full_reg |=> status_o.rx_overrun_flag && $stable(rd_data_o);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not handled");

    property p_fault_off;
        $rose(status_o.mode_fault_flag) |-> !port_enable_o && !master_select_o;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("fault kept port on");

    property p_soft_fault;
        master_reg && ctrl_reg.soft_select_mode && !ctrl_reg.soft_select_level
            |=> status_o.mode_fault_flag;
    endproperty
    a_soft_fault: assert property (p_soft_fault) else $error("soft select fault missed");

    property p_crc_err;
        rx_done && crc_frame_reg && rx_word != rx_crc_reg |=> ##[0:2] status_o.crc_mismatch_flag;
    endproperty
    a_crc_err: assert property (p_crc_err) else $error("crc mismatch not flagged");

    property p_irq;
        ctrl_b_i.error_irq_enable && status_o.rx_overrun_flag |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("error interrupt missing");

    property p_active;
        state_reg == ST_SHIFT |=> status_o.shift_active_flag;
    endproperty
    a_active: assert property (p_active) else $error("active flag low mid frame");

    c_frame: cover property (frame_end && rx_keep == 1'b0);
    c_overrun: cover property (rx_keep && rx_full_reg);
    c_crc_frame: cover property (rx_done && crc_frame_reg);
    c_fault: cover property ($rose(status_o.mode_fault_flag));
endmodule
`default_nettype wire

// file: rtl/spfc_pkg.sv
// Shared types and constants of the serial port status, CRC and DMA-request block
package spfc_pkg;
    localparam int FRAME_BITS = 8;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SCK_PERIOD_NS = 320;
    // Master serial clock half period in system clocks, rounded down, at least one
    localparam int SCK_HALF_CYCLES = (SCK_PERIOD_NS / (2 * CLK_PERIOD_NS) < 1) ? 1 :
        SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [7:0] RST_WORD = 8'h00;
    localparam logic [7:0] RST_CRC = 8'h00;

    typedef struct packed {
        logic port_enable;
        logic master_select;
        logic crc_enable;
        logic crc_next_transfer;
        logic soft_select_mode;
        logic soft_select_level;
        logic rx_only;
        logic tx_only;
    } spfc_ctrl_a_type;

    typedef struct packed {
        logic dma_tx_request_enable;
        logic dma_rx_request_enable;
        logic select_output_drive;
        logic ti_mode;
        logic tx_empty_irq_enable;
        logic rx_full_irq_enable;
        logic error_irq_enable;
    } spfc_ctrl_b_type;

    typedef struct packed {
        logic tx_buffer_empty;
        logic rx_full;
        logic shift_active_flag;
        logic mode_fault_flag;
        logic rx_overrun_flag;
        logic frame_sync_error;
        logic crc_mismatch_flag;
    } spfc_status_type;

    localparam spfc_ctrl_a_type RST_CTRL_A = '0;
endpackage

// file: verification/spfc_partner.sv
// Serial slave model answering the port's master clock in mode 0
`timescale 1ns/1ps
`default_nettype none
module spfc_partner (
    input wire logic sck_i,
    input wire logic nss_i,
    input wire logic nss_oe_i,
    input wire logic mosi_i,
    input wire logic [7:0] tx_byte_i,
    output logic miso_o,
    output var logic [7:0] rx_byte_o
);
    logic [2:0] idx_reg = 3'h0;
    logic bit_w;
    assign bit_w = tx_byte_i[3'h7 - idx_reg];
    // Deselected line shows the inverse, never a held value
    assign miso_o = (nss_oe_i && !nss_i) ? bit_w : ~bit_w;
    always_ff @(posedge sck_i) begin
        rx_byte_o <= {rx_byte_o[6:0], mosi_i};
    end
    // Eight falls per frame wrap the index back to the top bit
    // Count only while selected, so the clock settling out of reset cannot skew the index
    always @(negedge sck_i) begin
        if (nss_oe_i && !nss_i) begin
            idx_reg <= idx_reg + 3'h1;
        end else begin
            idx_reg <= 3'h0;
        end
    end
endmodule
`default_nettype wire

// file: verification/spfc_port_test.sv
// Self-checking bench of the serial port flags, CRC and DMA requests
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module spfc_port_test;
    logic clk_i = 1'b0, rst_n_i = 1'b0, ctrl_a_wr_i = 1'b0, data_wr_i = 1'b0;
    logic data_rd_i = 1'b0, status_rd_i = 1'b0, status_wr_i = 1'b0, rx_prev = 1'b0;
    spfc_pkg::spfc_ctrl_a_type ctrl_a_i = '0;
    spfc_pkg::spfc_ctrl_b_type ctrl_b_i = '0;
    spfc_pkg::spfc_status_type status_i = '0, status_o;
    logic [7:0] crc_poly_i = 8'h07, data_i = 8'h00, pb = 8'h00, d = 8'h00, d2;
    logic [7:0] rd_data_o, tx_check_o, rx_check_o, prx;
    logic port_enable_o, master_select_o, dma_tx_req_o, dma_rx_req_o, irq_o;
    logic sck_o, sck_oe_o, nss_o, nss_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
    logic p_miso, miso_w, nss_pin = 1'b1;
    int err_count = 0, n_compared = 0, seed = 93505, i;
    logic [7:0] exp_q[$];

    always #20 clk_i = ~clk_i;
    assign miso_w = miso_oe_o ? miso_o : p_miso;

    spfc_port #(.HALF_CYCLES(4)) DUT (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ctrl_a_wr_i(ctrl_a_wr_i), .ctrl_a_i(ctrl_a_i),
        .ctrl_b_i(ctrl_b_i), .crc_poly_i(crc_poly_i), .data_wr_i(data_wr_i),
        .data_i(data_i), .data_rd_i(data_rd_i), .status_rd_i(status_rd_i),
        .status_wr_i(status_wr_i), .status_i(status_i), .dma_last_i(1'b0),
        .sck_i(1'b0), .nss_i(nss_pin), .mosi_i(1'b0), .miso_i(miso_w),
        .rd_data_o(rd_data_o), .status_o(status_o), .port_enable_o(port_enable_o),
        .master_select_o(master_select_o), .tx_check_o(tx_check_o),
        .rx_check_o(rx_check_o), .dma_tx_req_o(dma_tx_req_o),
        .dma_rx_req_o(dma_rx_req_o), .irq_o(irq_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
        .nss_o(nss_o), .nss_oe_o(nss_oe_o), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
        .miso_o(miso_o), .miso_oe_o(miso_oe_o));

    spfc_partner partner (.sck_i(sck_o), .nss_i(nss_o), .nss_oe_i(nss_oe_o),
        .mosi_i(mosi_o), .tx_byte_i(pb), .miso_o(p_miso), .rx_byte_o(prx));

    task automatic tick;
        @(posedge clk_i);
        #2;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask

    task automatic wa(input logic [7:0] v);
        ctrl_a_i = v;
        pulse(ctrl_a_wr_i);
    endtask

    task automatic summarize;
        $display("counts: %0d compared, %0d mismatches", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Sel 0 waits on receive full, sel 1 on shift active
    task automatic wait_for(input int sel, input logic v);
        for (i = 0; i < 400; i++) begin
            if ((sel == 0 ? status_o.rx_full : status_o.shift_active_flag) === v) return;
            tick();
        end
        err_count++;
        $display("[ERR] wait %0d exp %0h got timeout", sel, v);
        summarize();
    endtask

    function automatic logic [7:0] crc8(input logic [7:0] b, input logic [7:0] p);
        logic [7:0] c;
        c = 8'h00;
        for (int k = 7; k >= 0; k--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[k]) ? p : 8'h00);
        return c;
    endfunction

    // Each new receive word is matched against the oldest note
    always @(posedge clk_i) begin
        rx_prev <= status_o.rx_full;
        if (status_o.rx_full === 1'b1 && rx_prev !== 1'b1) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("[ERR] rd_data exp none got %0h", rd_data_o);
            end else begin
                d2 = exp_q.pop_front();
                `CHK("rd_data", d2, rd_data_o)
            end
        end
    end

    initial begin
        repeat (10) tick();
        rst_n_i = 1'b1;
        tick();
        `CHK("status", 7'h40, status_o)
        crc_poly_i = 8'($random(seed));
        pb = 8'($random(seed));
        d = 8'($random(seed));
        ctrl_b_i.dma_tx_request_enable = 1'b1;
        ctrl_b_i.select_output_drive = 1'b1;
        wa(8'hEC);
        repeat (3) tick();
        `CHK("dma_tx_req", 1'b1, dma_tx_req_o)
        ctrl_b_i.dma_tx_request_enable = 1'b0;
        exp_q.push_back(pb);
        data_i = d;
        pulse(data_wr_i);
        wait_for(1, 1'b1);
        `CHK("tx_empty", 1'b1, status_o.tx_buffer_empty)
        wait_for(0, 1'b1);
        wait_for(1, 1'b0);
        `CHK("partner_rx", d, prx)
        `CHK("tx_check", crc8(d, crc_poly_i), tx_check_o)
        `CHK("rx_check", crc8(pb, crc_poly_i), rx_check_o)
        pulse(data_rd_i);
        tick();
        `CHK("rx_full", 1'b0, status_o.rx_full)
        // Stop only after last read, empty buffer and idle shifter
        wa(8'h6C);
        tick();
        ctrl_b_i.dma_rx_request_enable = 1'b1;
        pb = 8'($random(seed));
        exp_q.push_back(pb);
        wa(8'hCE);
        wait_for(0, 1'b1);
        repeat (3) tick();
        `CHK("dma_rx_req", 1'b1, dma_rx_req_o)
        // Unread word while the clock keeps running
        repeat (160) tick();
        `CHK("overrun", 1'b1, status_o.rx_overrun_flag)
        `CHK("rd_data_kept", pb, rd_data_o)
        // Disable, let the frame in flight finish, then read
        wa(8'h4C);
        wait_for(1, 1'b0);
        pulse(data_rd_i);
        pulse(status_rd_i);
        tick();
        `CHK("overrun", 1'b0, status_o.rx_overrun_flag)
        wa(8'hC8);
        repeat (2) tick();
        `CHK("fault", 1'b1, status_o.mode_fault_flag)
        `CHK("enables", 2'h0, {port_enable_o, master_select_o})
        wa(8'hCC);
        tick();
        `CHK("locked", 1'b0, port_enable_o)
        pulse(status_wr_i);
        wa(8'hCC);
        tick();
        `CHK("fault_clr", 1'b0, status_o.mode_fault_flag)
        wa(8'hCC);
        tick();
        `CHK("enable", 1'b1, port_enable_o)
        // CRC frame after the last word; partner answers with a corrupted CRC
        wa(8'hEC);
        pb = 8'($random(seed));
        d = 8'($random(seed));
        exp_q.push_back(pb);
        exp_q.push_back(crc8(pb, crc_poly_i) ^ 8'h01);
        data_i = d;
        pulse(data_wr_i);
        wa(8'hFC);
        wait_for(0, 1'b1);
        pb = crc8(pb, crc_poly_i) ^ 8'h01;
        pulse(data_rd_i);
        wait_for(0, 1'b1);
        wait_for(1, 1'b0);
        `CHK("partner_crc", crc8(d, crc_poly_i), prx)
        `CHK("crc_err", 1'b1, status_o.crc_mismatch_flag)
        pulse(status_wr_i);
        `CHK("crc_clr", 1'b0, status_o.crc_mismatch_flag)
        // Hardware select pulled low by another master
        nss_pin = 1'b0;
        ctrl_b_i.select_output_drive = 1'b0;
        wa(8'hC0);
        repeat (4) tick();
        `CHK("hw_fault", 1'b1, status_o.mode_fault_flag)
        `CHK("hw_off", 2'h0, {port_enable_o, master_select_o})
        summarize();
    end
endmodule
`default_nettype wire
